// >>> inc/eca_pkg.sv
package eca_pkg;

   // timing
   localparam int           CLK_HZ      = 100_000_000;
   localparam int           UART_BAUD   = 115200;
   localparam logic [9:0]   BAUD_DIV    = 10'(CLK_HZ / UART_BAUD);
   localparam logic [9:0]   BAUD_HALF   = 10'(CLK_HZ / UART_BAUD / 2);
   localparam int           RESP_TO_US  = 10000;
   localparam int           RESP_TO_CYC = RESP_TO_US * (CLK_HZ / 1_000_000);
   localparam int           TO_W        = 20;

   // frame bytes
   localparam logic [7:0]   FR_SYNC     = 8'h80;
   localparam logic [7:0]   FR_NODE     = 8'h01;
   localparam logic [7:0]   CMD_RD      = 8'h01;
   localparam logic [7:0]   CMD_WR      = 8'h02;
   localparam logic [7:0]   CMD_POS     = 8'h03;
   localparam logic [7:0]   LEN_RD      = 8'h02;
   localparam logic [7:0]   LEN_WR      = 8'h03;
   localparam logic [7:0]   LEN_POS     = 8'h01;
   localparam logic [7:0]   POS_ARG     = 8'h01;
   localparam logic [7:0]   RLEN_ONE    = 8'h01;
   localparam logic [7:0]   RLEN_POS    = 8'h05;
   localparam logic [7:0]   WR_ACK      = 8'h90;
   localparam logic [7:0]   WR_NAK      = 8'hA0;
   localparam logic [3:0]   HDR_BYTES   = 4'h5;

   // device register map
   localparam logic [6:0]   DEV_BANK    = 7'h40;
   localparam logic [6:0]   DEV_TEMP    = 7'h66;
   localparam logic [6:0]   DEV_MODE    = 7'h6A;
   localparam logic [6:0]   DEV_KEY     = 7'h6B;
   localparam logic [7:0]   KEY_VAL     = 8'h2A;
   localparam logic [7:0]   MODE_NORMAL = 8'h00;
   localparam logic [7:0]   MODE_CAL    = 8'h01;
   localparam logic [7:0]   MODE_PULSE  = 8'h02;
   localparam logic [7:0]   MODE_UDATA  = 8'h04;
   localparam logic [7:0]   MODE_FILT   = 8'h05;
   localparam logic [7:0]   MODE_PRESET = 8'h07;

   // host register offsets
   localparam logic [7:0]   HR_CTRL     = 8'h00;
   localparam logic [7:0]   HR_STAT     = 8'h04;
   localparam logic [7:0]   HR_RDAT     = 8'h08;
   localparam logic [7:0]   HR_POSL     = 8'h0C;
   localparam logic [7:0]   HR_POSH     = 8'h10;

   // control fields and status bits
   localparam int           CF_OP_LSB   = 0;
   localparam int           CF_ADDR_LSB = 8;
   localparam int           CF_DATA_LSB = 16;
   localparam int           CF_BANK_LSB = 24;
   localparam int           SB_BUSY     = 0;
   localparam int           SB_DONE     = 1;
   localparam int           SB_ERR      = 2;
   localparam int           SB_NAK      = 3;

   // operations
   localparam logic [2:0]   OP_RD       = 3'h1;
   localparam logic [2:0]   OP_WR       = 3'h2;
   localparam logic [2:0]   OP_POS      = 3'h3;
   localparam logic [2:0]   OP_MODE     = 3'h4;
   localparam logic [2:0]   OP_BRD      = 3'h5;
   localparam logic [2:0]   OP_BWR      = 3'h6;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SEND = 2'b01,
      ST_RECV = 2'b10
   } eca_state_t;

endpackage : eca_pkg

// >>> design/eca_uart.sv
`timescale 1ns/100ps
module eca_uart import eca_pkg::*; (
   // clock, reset, enable
   input  wire logic       core_clk,
   input  wire logic       nrst,
   input  wire logic       ce,
   // transmit side
   input  wire logic       tx_valid,
   input  wire logic [7:0] tx_data,
   output logic            tx_ready,
   // receive side
   output logic            rx_valid,
   output logic [7:0]      rx_data,
   // line
   output logic            txd,
   output logic            txd_oe,
   input  wire logic       rxd
);

   logic [3:0] tx_bit_r, tx_bit_nxt;
   logic [9:0] tx_cnt_r, tx_cnt_nxt;
   logic [9:0] tx_sh_r,  tx_sh_nxt;
   logic [3:0] rx_bit_r, rx_bit_nxt;
   logic [9:0] rx_cnt_r, rx_cnt_nxt;
   logic [7:0] rx_sh_r,  rx_sh_nxt;
   logic       rx_vld_r, rx_vld_nxt;
   logic [7:0] rx_dat_r, rx_dat_nxt;

   assign tx_ready = (tx_bit_r == 4'h0);
   assign txd_oe   = ~tx_ready;
   assign txd      = tx_sh_r[0];
   assign rx_valid = rx_vld_r;
   assign rx_data  = rx_dat_r;

   // 8n1 transmitter, one bit per baud period
   always_comb begin
      tx_bit_nxt = tx_bit_r;
      tx_cnt_nxt = tx_cnt_r;
      tx_sh_nxt  = tx_sh_r;
      if (tx_bit_r == 4'h0) begin
         if (tx_valid) begin
            tx_sh_nxt  = {1'b1, tx_data, 1'b0};
            tx_bit_nxt = 4'hA;
            tx_cnt_nxt = BAUD_DIV - 10'h001;
         end
      end else if (tx_cnt_r == 10'h000) begin
         tx_sh_nxt  = {1'b1, tx_sh_r[9:1]};
         tx_bit_nxt = tx_bit_r - 4'h1;
         tx_cnt_nxt = BAUD_DIV - 10'h001;
      end else begin
         tx_cnt_nxt = tx_cnt_r - 10'h001;
      end
   end

   // receiver samples mid-bit, drops false start and bad stop
   always_comb begin
      rx_bit_nxt = rx_bit_r;
      rx_cnt_nxt = rx_cnt_r;
      rx_sh_nxt  = rx_sh_r;
      rx_vld_nxt = 1'b0;
      rx_dat_nxt = rx_dat_r;
      if (rx_bit_r == 4'h0) begin
         if (!rxd) begin
            rx_bit_nxt = 4'hA;
            rx_cnt_nxt = BAUD_HALF - 10'h001;
         end
      end else if (rx_cnt_r != 10'h000) begin
         rx_cnt_nxt = rx_cnt_r - 10'h001;
      end else begin
         rx_cnt_nxt = BAUD_DIV - 10'h001;
         rx_bit_nxt = rx_bit_r - 4'h1;
         if (rx_bit_r == 4'hA) begin
            if (rxd) begin
               rx_bit_nxt = 4'h0;
            end
         end else if (rx_bit_r == 4'h1) begin
            rx_vld_nxt = rxd;
            rx_dat_nxt = rxd ? rx_sh_r : rx_dat_r;
         end else begin
            rx_sh_nxt = {rxd, rx_sh_r[7:1]};
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         tx_bit_r <= 4'h0;
         tx_cnt_r <= 10'h000;
         tx_sh_r  <= 10'h3FF;
         rx_bit_r <= 4'h0;
         rx_cnt_r <= 10'h000;
         rx_sh_r  <= 8'h00;
         rx_vld_r <= 1'b0;
         rx_dat_r <= 8'h00;
      end else if (ce) begin
         tx_bit_r <= tx_bit_nxt;
         tx_cnt_r <= tx_cnt_nxt;
         tx_sh_r  <= tx_sh_nxt;
         rx_bit_r <= rx_bit_nxt;
         rx_cnt_r <= rx_cnt_nxt;
         rx_sh_r  <= rx_sh_nxt;
         rx_vld_r <= rx_vld_nxt;
         rx_dat_r <= rx_dat_nxt;
      end
   end

endmodule : eca_uart

// >>> design/eca_host.sv
// Functional notes
// - select bank first, then access banked address
// - both links reach the same register space
// - uart 115200 baud, 8N1
// - frame: 0x80, node 0x01, cmd, length, payload, checksum
// - length counts payload bytes only
// - checksum is inverted sum of preceding bytes
// - read request: cmd 0x01, length 0x02
// - write request: cmd 0x02, length 0x03
// - position request: cmd 0x03, length 1, byte 0x01
// - password 0x2A to 0x6B before mode write 0x6A
// - restore normal mode after features; limit flash writes
// - serial link access: 7-bit address, rw 10/01
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/100ps
module eca_host import eca_pkg::*; #(
   parameter int RESP_TO_CYC_P = RESP_TO_CYC
) (
   // clock, reset, enable
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic        ce,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // config pin
   input  wire logic        cfg_pin_i,
   output logic             cfg_pin_o,
   output logic             cfg_pin_oe
);

   localparam logic [TO_W-1:0] TO_LAST = TO_W'(RESP_TO_CYC_P - 1);

   eca_state_t  state_r, state_nxt;
   logic [2:0]  op_r,    op_nxt;
   logic [6:0]  addr_r,  addr_nxt;
   logic [7:0]  data_r,  data_nxt;
   logic [7:0]  bank_r,  bank_nxt;
   logic        step_r,  step_nxt;
   logic [3:0]  idx_r,   idx_nxt;
   logic [7:0]  sum_r,   sum_nxt;
   logic [TO_W-1:0] to_r, to_nxt;
   logic [39:0] pbuf_r,  pbuf_nxt;
   logic [32:0] pos_r,   pos_nxt;
   logic [7:0]  rdat_r,  rdat_nxt;
   logic        done_r,  done_nxt;
   logic        err_r,   err_nxt;
   logic        nak_r,   nak_nxt;
   logic        pw_ok_r, pw_ok_nxt;
   logic        ahb_wr_r, ahb_wr_nxt;
   logic [7:0]  ahb_a_r, ahb_a_nxt;
   logic [31:0] hrdata_r, hrdata_nxt;

   logic        tx_valid;
   logic        tx_ready;
   logic [7:0]  tx_byte;
   logic        rx_valid;
   logic [7:0]  rx_data;
   logic [7:0]  f_cmd;
   logic [6:0]  f_reg;
   logic [7:0]  f_dat;
   logic [7:0]  f_len;
   logic [7:0]  f_rlen;
   logic        last_step;
   logic [7:0]  exp_byte;
   logic [31:0] stat_w;
   logic [3:0]  chk_idx;
   logic [3:0]  rchk_idx;
   logic        aphase;
   logic        wr_ctrl;
   logic        wr_stat;
   logic        start;
   logic        busy;

   eca_uart u_uart (
      .core_clk (core_clk),
      .nrst     (nrst),
      .ce       (ce),
      .tx_valid (tx_valid),
      .tx_data  (tx_byte),
      .tx_ready (tx_ready),
      .rx_valid (rx_valid),
      .rx_data  (rx_data),
      .txd      (cfg_pin_o),
      .txd_oe   (cfg_pin_oe),
      .rxd      (cfg_pin_i)
   );

   // bus slave
   assign hreadyout = ce;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_r;
   assign aphase    = hsel & htrans[1] & hready;
   assign wr_ctrl   = ahb_wr_r & (ahb_a_r == HR_CTRL);
   assign wr_stat   = ahb_wr_r & (ahb_a_r == HR_STAT);
   assign busy      = (state_r != ST_IDLE);
   assign start     = wr_ctrl & ~busy & (hwdata[CF_OP_LSB +: 3] >= OP_RD) & (hwdata[CF_OP_LSB +: 3] <= OP_BWR);

   always_comb begin
      stat_w          = 32'h0000_0000;
      stat_w[SB_BUSY] = busy;
      stat_w[SB_DONE] = done_r;
      stat_w[SB_ERR]  = err_r;
      stat_w[SB_NAK]  = nak_r;
   end

   always_comb begin
      ahb_wr_nxt = aphase & hwrite;
      ahb_a_nxt  = aphase ? haddr[7:0] : ahb_a_r;
      hrdata_nxt = hrdata_r;
      if (aphase & ~hwrite) begin
         case (haddr[7:0])
            HR_STAT: hrdata_nxt = stat_w;
            HR_RDAT: hrdata_nxt = {24'h000000, rdat_r};
            HR_POSL: hrdata_nxt = pos_r[31:0];
            HR_POSH: hrdata_nxt = {31'h00000000, pos_r[32]};
            default: hrdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         ahb_wr_r <= 1'b0;
         ahb_a_r  <= 8'h00;
         hrdata_r <= 32'h0000_0000;
      end else if (ce) begin
         ahb_wr_r <= ahb_wr_nxt;
         ahb_a_r  <= ahb_a_nxt;
         hrdata_r <= hrdata_nxt;
      end
   end

   // frame of the current step; register numbers are the device's own map
   always_comb begin
      f_cmd     = CMD_RD;
      f_reg     = addr_r;
      f_dat     = data_r;
      last_step = 1'b1;
      case (op_r)
         OP_WR:  f_cmd = CMD_WR;
         OP_POS: f_cmd = CMD_POS;
         OP_MODE: begin
            // data 0x00 restores normal operation after a feature
            f_cmd     = CMD_WR;
            f_reg     = step_r ? DEV_MODE : DEV_KEY;
            f_dat     = step_r ? data_r : KEY_VAL;
            last_step = step_r;
         end
         OP_BRD, OP_BWR: begin
            f_cmd     = (step_r && op_r == OP_BRD) ? CMD_RD : CMD_WR;
            f_reg     = step_r ? {1'b0, addr_r[5:0]} : DEV_BANK;
            f_dat     = step_r ? data_r : bank_r;
            last_step = step_r;
         end
         default: f_cmd = CMD_RD;
      endcase
      f_len    = (f_cmd == CMD_RD) ? LEN_RD : (f_cmd == CMD_WR) ? LEN_WR : LEN_POS;
      f_rlen   = (f_cmd == CMD_POS) ? RLEN_POS : RLEN_ONE;
      chk_idx  = HDR_BYTES + f_len[3:0];
      rchk_idx = HDR_BYTES + f_rlen[3:0];
   end

   // outgoing byte; register number goes as two bytes, low first
   always_comb begin
      case (idx_r)
         4'h0: tx_byte = FR_SYNC;
         4'h1: tx_byte = FR_NODE;
         4'h2: tx_byte = f_cmd;
         4'h3: tx_byte = f_len;
         4'h4: tx_byte = 8'h00;
         4'h5: tx_byte = (f_cmd == CMD_POS) ? POS_ARG : {1'b0, f_reg};
         4'h6: tx_byte = 8'h00;
         4'h7: tx_byte = f_dat;
         default: tx_byte = 8'h00;
      endcase
      if (idx_r == chk_idx) begin
         tx_byte = ~sum_r;
      end
   end

   always_comb begin
      case (idx_r)
         4'h1: exp_byte = FR_NODE;
         4'h2: exp_byte = f_cmd;
         4'h3: exp_byte = f_rlen;
         default: exp_byte = 8'h00;
      endcase
   end

   // transaction sequencer
   always_comb begin
      state_nxt = state_r;
      op_nxt    = op_r;
      addr_nxt  = addr_r;
      data_nxt  = data_r;
      bank_nxt  = bank_r;
      step_nxt  = step_r;
      idx_nxt   = idx_r;
      sum_nxt   = sum_r;
      to_nxt    = to_r;
      pbuf_nxt  = pbuf_r;
      pos_nxt   = pos_r;
      rdat_nxt  = rdat_r;
      done_nxt  = done_r & ~(wr_stat & hwdata[SB_DONE]);
      err_nxt   = err_r & ~(wr_stat & hwdata[SB_ERR]);
      nak_nxt   = nak_r & ~(wr_stat & hwdata[SB_NAK]);
      pw_ok_nxt = pw_ok_r;
      tx_valid  = 1'b0;
      case (state_r)
         ST_IDLE: begin
            if (start) begin
               op_nxt    = hwdata[CF_OP_LSB +: 3];
               addr_nxt  = hwdata[CF_ADDR_LSB +: 7];
               data_nxt  = hwdata[CF_DATA_LSB +: 8];
               bank_nxt  = hwdata[CF_BANK_LSB +: 8];
               step_nxt  = 1'b0;
               idx_nxt   = 4'h0;
               sum_nxt   = 8'h00;
               done_nxt  = 1'b0;
               err_nxt   = 1'b0;
               nak_nxt   = 1'b0;
               pw_ok_nxt = 1'b0;
               state_nxt = ST_SEND;
            end
         end
         ST_SEND: begin
            tx_valid = 1'b1;
            if (tx_ready) begin
               sum_nxt = sum_r + tx_byte;
               idx_nxt = idx_r + 4'h1;
               if (idx_r == chk_idx) begin
                  idx_nxt   = 4'h0;
                  sum_nxt   = 8'h00;
                  to_nxt    = '0;
                  state_nxt = ST_RECV;
               end
            end
         end
         ST_RECV: begin
            to_nxt = to_r + 1'b1;
            if (to_r == TO_LAST) begin
               err_nxt   = 1'b1;
               state_nxt = ST_IDLE;
            end else if (rx_valid && tx_ready) begin
               // own echo is ignored while still sending
               sum_nxt = sum_r + rx_data;
               idx_nxt = idx_r + 4'h1;
               if (idx_r == 4'h0) begin
                  if (rx_data != FR_SYNC) begin
                     idx_nxt = 4'h0;
                     sum_nxt = 8'h00;
                  end
               end else if (idx_r < HDR_BYTES) begin
                  if (rx_data != exp_byte) begin
                     err_nxt   = 1'b1;
                     state_nxt = ST_IDLE;
                  end
               end else if (idx_r == rchk_idx) begin
                  if (rx_data != ~sum_r) begin
                     err_nxt   = 1'b1;
                     state_nxt = ST_IDLE;
                  end else begin
                     if (f_cmd == CMD_POS) begin
                        pos_nxt = pbuf_r[32:0];
                     end else begin
                        rdat_nxt = pbuf_r[39:32];
                     end
                     if (f_cmd == CMD_WR && f_reg == DEV_KEY && f_dat == KEY_VAL && pbuf_r[39:32] == WR_ACK) begin
                        pw_ok_nxt = 1'b1;
                     end
                     if (f_cmd == CMD_WR && pbuf_r[39:32] != WR_ACK) begin
                        nak_nxt   = 1'b1;
                        state_nxt = ST_IDLE;
                     end else if (last_step) begin
                        done_nxt  = 1'b1;
                        state_nxt = ST_IDLE;
                     end else begin
                        step_nxt  = 1'b1;
                        idx_nxt   = 4'h0;
                        sum_nxt   = 8'h00;
                        state_nxt = ST_SEND;
                     end
                  end
               end else begin
                  pbuf_nxt = {rx_data, pbuf_r[39:8]};
               end
            end
         end
         default: state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         state_r <= ST_IDLE;
         op_r    <= 3'h0;
         addr_r  <= 7'h00;
         data_r  <= 8'h00;
         bank_r  <= 8'h00;
         step_r  <= 1'b0;
         idx_r   <= 4'h0;
         sum_r   <= 8'h00;
         to_r    <= '0;
         pbuf_r  <= 40'h00_0000_0000;
         pos_r   <= 33'h0_0000_0000;
         rdat_r  <= 8'h00;
         done_r  <= 1'b0;
         err_r   <= 1'b0;
         nak_r   <= 1'b0;
         pw_ok_r <= 1'b0;
      end else if (ce) begin
         state_r <= state_nxt;
         op_r    <= op_nxt;
         addr_r  <= addr_nxt;
         data_r  <= data_nxt;
         bank_r  <= bank_nxt;
         step_r  <= step_nxt;
         idx_r   <= idx_nxt;
         sum_r   <= sum_nxt;
         to_r    <= to_nxt;
         pbuf_r  <= pbuf_nxt;
         pos_r   <= pos_nxt;
         rdat_r  <= rdat_nxt;
         done_r  <= done_nxt;
         err_r   <= err_nxt;
         nak_r   <= nak_nxt;
         pw_ok_r <= pw_ok_nxt;
      end
   end

   // checks
   logic fire;
   assign fire = ce & tx_valid & tx_ready;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   sync_byte_a: assert property (fire && idx_r == 4'h0 |-> tx_byte == 8'h80)
      else $error("sync byte wrong");
   node_byte_a: assert property (fire && idx_r == 4'h1 |-> tx_byte == 8'h01)
      else $error("node byte wrong");
   len_high_a: assert property (fire && idx_r == 4'h3 |-> tx_byte == f_len ##1
      idx_r == 4'h4 && tx_byte == 8'h00)
      else $error("length field wrong");
   rd_len_a: assert property (fire && idx_r == 4'h3 && f_cmd == 8'h01 |-> tx_byte == 8'h02)
      else $error("read length wrong");
   wr_len_a: assert property (fire && idx_r == 4'h3 && f_cmd == 8'h02 |-> tx_byte == 8'h03)
      else $error("write length wrong");
   pos_arg_a: assert property (fire && idx_r == 4'h5 && f_cmd == 8'h03 |-> tx_byte == 8'h01 ##1 idx_r == 4'h6)
      else $error("position request wrong");
   chk_byte_a: assert property (fire && idx_r == chk_idx |-> tx_byte == ~sum_r ##1 state_r == ST_RECV)
      else $error("checksum or end of send wrong");
   mode_key_a: assert property (fire && idx_r == 4'h5 && op_r == OP_MODE && step_r |-> pw_ok_r)
      else $error("mode write without password");
   bank_first_a: assert property (fire && idx_r == 4'h5 && step_r && op_r >= 3'h5 |-> tx_byte < 8'h40 && bank_r == $past(bank_r))
      else $error("banked access not low half");

endmodule : eca_host

// >>> tb/eca_dev.sv
`timescale 1ns/100ps
module eca_dev import eca_pkg::*; #(
   parameter logic [7:0]  TEMP_RAW = 8'h4B,
   parameter logic [32:0] POS      = 33'h1_5A5A_3C3C
) (
   // clock and line
   input  wire logic        core_clk,
   input  wire logic        line,
   // fault and pacing
   input  wire logic        bad_chk,
   input  wire logic [31:0] gap,
   // drive
   output logic             txo,
   output logic             txoe
);
   logic [7:0] dreg [64];
   logic [7:0] bk   [68][64];
   logic [7:0] p    [8];
   logic [7:0] r    [5];
   logic [7:0] b, nd, cm, ll, lh, ck, sm;
   logic [6:0] a;
   int         n;

   task automatic tick(input int c);
      repeat (c) @(posedge core_clk);
   endtask : tick

   // receive one 8N1 byte, add it to the running sum
   task automatic rxb(output logic [7:0] v);
      do @(posedge core_clk); while (line !== 1'b0);
      tick(int'(BAUD_HALF));
      for (int i = 0; i < 8; i++) begin
         tick(int'(BAUD_DIV));
         v[i] = line;
      end
      tick(int'(BAUD_DIV));
      sm = sm + v;
   endtask : rxb

   // last byte releases after half its stop bit; pull-up holds the line high
   task automatic txb(input logic [7:0] v, input logic last);
      logic [9:0] f;
      f = {1'b1, v, 1'b0};
      for (int i = 0; i < 10; i++) begin
         txo <= f[i];
         tick((last && i == 9) ? int'(BAUD_HALF) : int'(BAUD_DIV));
      end
   endtask : txb

   function automatic logic [7:0] rd(input logic [6:0] ad);
      if (ad[6]) return dreg[ad[5:0]];
      return (dreg[0] < 8'h44) ? bk[dreg[0]][ad[5:0]] : 8'hFF;
   endfunction : rd

   initial begin
      txo = 1'b1;
      txoe = 1'b0;
      foreach (dreg[i]) dreg[i] = 8'h00;
      foreach (bk[i, j]) bk[i][j] = 8'h00;
      dreg[6'h26] = TEMP_RAW;
      forever begin
         sm = 8'h00;
         rxb(b);
         if (b !== FR_SYNC) continue;
         rxb(nd);
         rxb(cm);
         rxb(ll);
         rxb(lh);
         for (int i = 0; i < int'(ll) && i < 8; i++) rxb(p[i]);
         ck = ~sm;
         rxb(b);
         if (nd !== FR_NODE || b !== ck) continue;
         n = 1;
         a = p[0][6:0];
         if (cm == CMD_RD && ll == LEN_RD) r[0] = rd(a);
         else if (cm == CMD_WR && ll == LEN_WR) begin
            r[0] = (a == DEV_TEMP || (a == DEV_MODE && dreg[6'h2B] != KEY_VAL)) ? WR_NAK : WR_ACK;
            if (r[0] == WR_ACK && a[6]) dreg[a[5:0]] = p[2];
            else if (r[0] == WR_ACK && dreg[0] < 8'h44) bk[dreg[0]][a[5:0]] = p[2];
         end else if (cm == CMD_POS && ll == LEN_POS && p[0] == POS_ARG) begin
            n = 5;
            for (int i = 0; i < 5; i++) r[i] = 8'(POS >> (8 * i));
         end else continue;
         tick(int'(gap));
         ck = FR_SYNC + FR_NODE + cm + 8'(n);
         for (int i = 0; i < n; i++) ck = ck + r[i];
         txoe <= 1'b1;
         txb(FR_SYNC, 1'b0);
         txb(FR_NODE, 1'b0);
         txb(cm, 1'b0);
         txb(8'(n), 1'b0);
         txb(8'h00, 1'b0);
         for (int i = 0; i < n; i++) txb(r[i], 1'b0);
         txb(bad_chk ? ck : ~ck, 1'b1);
         txoe <= 1'b0;
      end
   end
endmodule : eca_dev

// >>> tb/eca_host_bench.sv
`timescale 1ns/100ps
module eca_host_bench import eca_pkg::*;;
   localparam logic [7:0]  TEMP = 8'h4B;
   localparam logic [32:0] POS  = 33'h1_5A5A_3C3C;
   logic        core_clk, nrst, ce, hsel, hwrite, bad_chk, txo, txoe;
   logic        hreadyout, hresp, cfg_pin_o, cfg_pin_oe;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, q, gap;
   wire         line;
   int          failures, n_checks;

   // pulled-up config pin
   assign line = cfg_pin_oe ? cfg_pin_o : (txoe ? txo : 1'b1);

   eca_host #(.RESP_TO_CYC_P(200000)) dut (.core_clk(core_clk), .nrst(nrst), .ce(ce), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cfg_pin_i(line), .cfg_pin_o(cfg_pin_o),
      .cfg_pin_oe(cfg_pin_oe));
   eca_dev #(.TEMP_RAW(TEMP), .POS(POS)) dev (.core_clk(core_clk), .line(line), .bad_chk(bad_chk), .gap(gap),
      .txo(txo), .txoe(txoe));

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= w;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask : bus

   task automatic idle;
      int k;
      k = 0;
      do begin
         bus(1'b0, HR_STAT, 32'h0);
         k++;
      end while (q[SB_BUSY] !== 1'b0 && k < 400000);
      chk("busy", 32'h0, {31'h0, q[SB_BUSY]});
   endtask : idle

   task automatic op(input logic [2:0] o, input logic [6:0] a, input logic [7:0] d, input logic [7:0] bk);
      bus(1'b1, HR_CTRL, {bk, d, 1'b0, a, 5'h00, o});
      @(posedge core_clk);
      idle();
   endtask : op

   task automatic conclude;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : conclude

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   initial begin
      repeat (2500000) @(posedge core_clk);
      failures++;
      conclude();
   end

   initial begin
      nrst = 1'b0;
      ce = 1'b1;
      hsel = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      bad_chk = 1'b0;
      gap = 32'h7D0;
      failures = 0;
      n_checks = 0;
      repeat (5) @(posedge core_clk);
      nrst <= 1'b1;
      @(posedge core_clk);
      chk("pin idle", 32'h1, {30'h0, cfg_pin_oe, cfg_pin_o});
      // enable low stalls the bus; response always okay
      ce <= 1'b0;
      @(posedge core_clk);
      chk("ce gate", 32'h0, {30'h0, hresp, hreadyout});
      ce <= 1'b1;
      bus(1'b0, HR_STAT, 32'h0);
      chk("stat reset", 32'h0, q);
      bus(1'b0, 8'h20, 32'h0);
      chk("unmapped", 32'h0, q);
      // temperature read, second order while busy is dropped
      bus(1'b1, HR_CTRL, {16'h0, 1'b0, DEV_TEMP, 5'h00, OP_RD});
      @(posedge core_clk);
      bus(1'b1, HR_CTRL, {16'h0, 1'b0, DEV_BANK, 5'h00, OP_RD});
      @(posedge core_clk);
      idle();
      chk("rd done", 32'h2, q);
      bus(1'b0, HR_RDAT, 32'h0);
      chk("temp", {24'h0, TEMP}, q);
      bus(1'b1, HR_STAT, 32'hE);
      bus(1'b0, HR_STAT, 32'h0);
      chk("w1c", 32'h0, q);
      // mode write without key
      op(OP_WR, DEV_MODE, MODE_CAL, 8'h00);
      chk("nak stat", 32'h8, q);
      bus(1'b0, HR_RDAT, 32'h0);
      chk("nak byte", {24'h0, WR_NAK}, q);
      op(OP_MODE, 7'h00, MODE_PRESET, 8'h00);
      chk("mode stat", 32'h2, q);
      chk("mode", {24'h0, MODE_PRESET}, {24'h0, dev.dreg[6'h2A]});
      // banked write then banked-address read
      op(OP_BWR, 7'h03, 8'h5A, 8'h05);
      chk("bwr stat", 32'h2, q);
      op(OP_RD, 7'h03, 8'h00, 8'h00);
      bus(1'b0, HR_RDAT, 32'h0);
      chk("banked", 32'h5A, q);
      // slow position answer
      gap = 32'h4E20;
      op(OP_POS, 7'h00, 8'h00, 8'h00);
      bus(1'b0, HR_POSL, 32'h0);
      chk("posl", POS[31:0], q);
      bus(1'b0, HR_POSH, 32'h0);
      chk("posh", {31'h0, POS[32]}, q);
      // corrupted reply checksum
      gap = 32'h7D0;
      bad_chk <= 1'b1;
      op(OP_RD, DEV_TEMP, 8'h00, 8'h00);
      chk("err", 32'h1, {31'h0, q[SB_ERR]});
      conclude();
   end
endmodule : eca_host_bench
